// *** src/ccmu_cfg.svh ***
// register map, field positions, mode codes and timing counts of the compare match unit
`ifndef CCMU_CFG_SVH
`define CCMU_CFG_SVH

// --------------------------------------------------------------
// register indices on the plain register port
// --------------------------------------------------------------
`define CCMU_ADDR_UNIT1_CTRL  4'h0
`define CCMU_ADDR_UNIT2_CTRL  4'h1
`define CCMU_ADDR_CMP1_LOW    4'h2
`define CCMU_ADDR_CMP1_HIGH   4'h3
`define CCMU_ADDR_CMP2_LOW    4'h4
`define CCMU_ADDR_CMP2_HIGH   4'h5
`define CCMU_ADDR_ALT_PIN     4'h6
`define CCMU_ADDR_IRQ_EN1     4'h7
`define CCMU_ADDR_IRQ_EN2     4'h8
`define CCMU_ADDR_IRQ_FLAG1   4'h9
`define CCMU_ADDR_IRQ_FLAG2   4'ha
`define CCMU_ADDR_TB_LOW      4'hb
`define CCMU_ADDR_TB_HIGH     4'hc
`define CCMU_ADDR_TB_CTRL     4'hd

// --------------------------------------------------------------
// fields and reset values
// --------------------------------------------------------------
`define CCMU_CTRL_MASK        8'h3f
`define CCMU_ALT_MASK         8'h03
`define CCMU_IRQ2_MASK        8'h01
`define CCMU_TBCTRL_MASK      8'h03
`define CCMU_RESET_BYTE       8'h00
`define CCMU_FLAG1_UNIT1_BIT  2
`define CCMU_FLAG1_OVF_BIT    0
`define CCMU_FLAG2_UNIT2_BIT  0
`define CCMU_ALT_UNIT2_BIT    0
`define CCMU_TBCTRL_ON_BIT    0
`define CCMU_TBCTRL_EXT_BIT   1

// --------------------------------------------------------------
// mode select codes
// --------------------------------------------------------------
`define CCMU_MODE_OFF         4'h0
`define CCMU_MODE_TOGGLE      4'h2
`define CCMU_MODE_SET         4'h8
`define CCMU_MODE_CLEAR       4'h9
`define CCMU_MODE_SWINT       4'ha
`define CCMU_MODE_SPECIAL     4'hb

// --------------------------------------------------------------
// timing: instruction clock is the system clock divided by four
// --------------------------------------------------------------
`define CCMU_INSTR_DIV_LAST   2'h3

`endif

// *** src/ccmu_pkg.sv ***
// types shared by the compare match unit
package ccmu_pkg;

  typedef logic [3:0] ccmu_mode_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } ccmu_bus_req_t;

  typedef struct packed {
    logic out;
    logic driveN;
  } ccmu_pin_t;

endpackage

// *** src/ccmu_compare_unit.sv ***
// two compare match units sharing one 16-bit time base, with register port and pin routing
//
// Notes on behaviour
// RULE_01: compare register continuously checked against time base
// RULE_02: match performs action chosen by mode
// RULE_03: decode toggle, set, clear, swint, special, off
// RULE_04: every compare mode sets match flag
// RULE_05: software alone clears match flag
// RULE_06: software interrupt mode leaves pin alone
// RULE_07: special event match resets time base
// RULE_08: only second unit starts conversion, when enabled
// RULE_09: special event mode never drives pin
// RULE_10: special trigger asserts in the equality cycle
// RULE_11: time base clears at next count edge
// RULE_12: special trigger never sets overflow flag
// RULE_13: removed match before edge cancels reset
// RULE_14: writing zero control forces latch low
// RULE_15: software sets pin direction to output
// RULE_16: software uses timer or synchronized counter
// RULE_17: time base never clocked at system rate
// RULE_18: instruction-clocked time base holds during sleep
// RULE_19: externally clocked time base runs during sleep
// RULE_20: second unit pin selectable between two pins
// RULE_21: software clears control before changing mode
// RULE_22: match fires once per count value
// RULE_23: pin driven only in toggle, set, clear
`include "ccmu_cfg.svh"

module ccmu_compare_unit
  import ccmu_pkg::*;
(
  input  wire logic          core_clk,
  input  wire logic          rst_n,
  input  wire ccmu_bus_req_t busReq,
  output logic [7:0]         busRdata,
  input  wire logic          sleepMode,
  input  wire logic          extClkPin,
  input  wire logic          adcEnabled,
  output ccmu_pin_t          unit1Pin,
  output ccmu_pin_t          portC1Pin,
  output ccmu_pin_t          portB3Pin,
  output logic [1:0]         specialTrigger,
  output logic               adcStart
);

  // --------------------------------------------------------------
  // decode helpers
  // --------------------------------------------------------------
  function automatic logic isCompareMode(input ccmu_mode_t m);
    return m inside {`CCMU_MODE_TOGGLE, `CCMU_MODE_SET, `CCMU_MODE_CLEAR,
                     `CCMU_MODE_SWINT, `CCMU_MODE_SPECIAL};
  endfunction

  function automatic logic drivesPin(input ccmu_mode_t m);
    return m inside {`CCMU_MODE_TOGGLE, `CCMU_MODE_SET, `CCMU_MODE_CLEAR};
  endfunction

  function automatic logic wrHit(input ccmu_bus_req_t r, input logic [3:0] a);
    return r.wr && (r.addr == a);
  endfunction

  // --------------------------------------------------------------
  // state
  // --------------------------------------------------------------
  logic [7:0]  unitCtrl [2];
  logic [15:0] cmpVal   [2];
  ccmu_mode_t  unitMode [2];
  logic [7:0]  altSel;
  logic [7:0]  irqEn1;
  logic [7:0]  irqEn2;
  logic [7:0]  irqFlag1;
  logic [7:0]  irqFlag2;
  logic [7:0]  tbCtrl;
  logic [15:0] timeBaseCount;
  logic [1:0]  cmpLatch;
  logic [1:0]  eqNow;
  logic [1:0]  eqPrev;
  logic [1:0]  matchEvent;
  logic [1:0]  specialHit;
  logic [1:0]  divCnt;
  logic        extSync1;
  logic        extSync2;
  logic        extSync3;
  logic        tick;
  logic        tbReset;
  logic        tbOverflow;
  logic        tbWrite;
  logic        unit2OnB3;

  // --------------------------------------------------------------
  // match detection
  // --------------------------------------------------------------
  always_comb begin
    for (int u = 0; u < 2; u++) begin
      unitMode[u]   = unitCtrl[u][3:0];
      eqNow[u]      = isCompareMode(unitMode[u]) && (cmpVal[u] == timeBaseCount); // [RULE_01]
      // one event per count value, even though the count holds for several cycles
      matchEvent[u] = eqNow[u] && !eqPrev[u]; // [RULE_22]
      specialHit[u] = eqNow[u] && (unitMode[u] == `CCMU_MODE_SPECIAL); // [RULE_07]
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      eqPrev <= 2'h0;
    end else begin
      eqPrev <= eqNow;
    end
  end

  // trigger is combinational so it stands in the very cycle of equality
  assign specialTrigger = specialHit; // [RULE_10]
  assign adcStart       = matchEvent[1] && (unitMode[1] == `CCMU_MODE_SPECIAL) && adcEnabled; // [RULE_08]

  // --------------------------------------------------------------
  // time base clocking
  // --------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      extSync1 <= 1'b0;
      extSync2 <= 1'b0;
      extSync3 <= 1'b0;
    end else begin
      extSync1 <= extClkPin;
      extSync2 <= extSync1;
      extSync3 <= extSync2;
    end
  end

  // instruction clock divider stops in sleep, so the held count resumes on wake
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      divCnt <= 2'h0;
    end else if (!sleepMode) begin // [RULE_18]
      divCnt <= divCnt + 2'h1;
    end
  end

  always_comb begin
    tick = 1'b0;
    if (tbCtrl[`CCMU_TBCTRL_ON_BIT]) begin
      if (tbCtrl[`CCMU_TBCTRL_EXT_BIT]) begin
        tick = extSync2 && !extSync3; // [RULE_19]
      end else begin
        tick = !sleepMode && (divCnt == `CCMU_INSTR_DIV_LAST); // [RULE_18]
      end
    end
  end

  // the match is sampled again at the count edge: a rewritten compare value cancels the reset
  assign tbReset    = tick && (|specialHit); // [RULE_11] [RULE_13]
  assign tbOverflow = tick && !tbReset && (timeBaseCount == 16'hffff); // [RULE_12]
  assign tbWrite    = wrHit(busReq, `CCMU_ADDR_TB_LOW) || wrHit(busReq, `CCMU_ADDR_TB_HIGH);

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      timeBaseCount <= 16'h0000;
    end else if (wrHit(busReq, `CCMU_ADDR_TB_LOW)) begin
      timeBaseCount[7:0] <= busReq.wdata;
    end else if (wrHit(busReq, `CCMU_ADDR_TB_HIGH)) begin
      timeBaseCount[15:8] <= busReq.wdata;
    end else if (tbReset) begin
      timeBaseCount <= 16'h0000; // [RULE_11]
    end else if (tick) begin
      timeBaseCount <= timeBaseCount + 16'h0001;
    end
  end

  // --------------------------------------------------------------
  // configuration registers
  // --------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      unitCtrl[0] <= `CCMU_RESET_BYTE;
      unitCtrl[1] <= `CCMU_RESET_BYTE;
    end else begin
      if (wrHit(busReq, `CCMU_ADDR_UNIT1_CTRL)) begin
        unitCtrl[0] <= busReq.wdata & `CCMU_CTRL_MASK; // [RULE_03]
      end
      if (wrHit(busReq, `CCMU_ADDR_UNIT2_CTRL)) begin
        unitCtrl[1] <= busReq.wdata & `CCMU_CTRL_MASK; // [RULE_03]
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cmpVal[0] <= 16'h0000;
      cmpVal[1] <= 16'h0000;
    end else begin
      if (wrHit(busReq, `CCMU_ADDR_CMP1_LOW)) begin
        cmpVal[0][7:0] <= busReq.wdata;
      end
      if (wrHit(busReq, `CCMU_ADDR_CMP1_HIGH)) begin
        cmpVal[0][15:8] <= busReq.wdata;
      end
      if (wrHit(busReq, `CCMU_ADDR_CMP2_LOW)) begin
        cmpVal[1][7:0] <= busReq.wdata;
      end
      if (wrHit(busReq, `CCMU_ADDR_CMP2_HIGH)) begin
        cmpVal[1][15:8] <= busReq.wdata;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      altSel <= `CCMU_RESET_BYTE;
      irqEn1 <= `CCMU_RESET_BYTE;
      irqEn2 <= `CCMU_RESET_BYTE;
      tbCtrl <= `CCMU_RESET_BYTE;
    end else begin
      if (wrHit(busReq, `CCMU_ADDR_ALT_PIN)) begin
        altSel <= busReq.wdata & `CCMU_ALT_MASK;
      end
      if (wrHit(busReq, `CCMU_ADDR_IRQ_EN1)) begin
        irqEn1 <= busReq.wdata;
      end
      if (wrHit(busReq, `CCMU_ADDR_IRQ_EN2)) begin
        irqEn2 <= busReq.wdata & `CCMU_IRQ2_MASK;
      end
      if (wrHit(busReq, `CCMU_ADDR_TB_CTRL)) begin
        tbCtrl <= busReq.wdata & `CCMU_TBCTRL_MASK;
      end
    end
  end

  // --------------------------------------------------------------
  // interrupt flags: hardware set wins over a software clear
  // --------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      irqFlag1 <= `CCMU_RESET_BYTE;
      irqFlag2 <= `CCMU_RESET_BYTE;
    end else begin
      irqFlag1 <= wrHit(busReq, `CCMU_ADDR_IRQ_FLAG1) ? busReq.wdata : irqFlag1;
      irqFlag2 <= wrHit(busReq, `CCMU_ADDR_IRQ_FLAG2) ? (busReq.wdata & `CCMU_IRQ2_MASK) : irqFlag2;
      if (matchEvent[0]) begin
        irqFlag1[`CCMU_FLAG1_UNIT1_BIT] <= 1'b1; // [RULE_04] [RULE_06]
      end
      if (tbOverflow) begin
        irqFlag1[`CCMU_FLAG1_OVF_BIT] <= 1'b1; // [RULE_12]
      end
      if (matchEvent[1]) begin
        irqFlag2[`CCMU_FLAG2_UNIT2_BIT] <= 1'b1; // [RULE_04]
      end
    end
  end

  // --------------------------------------------------------------
  // compare output latches
  // --------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cmpLatch <= 2'h0;
    end else begin
      for (int u = 0; u < 2; u++) begin
        if (wrHit(busReq, u[0] ? `CCMU_ADDR_UNIT2_CTRL : `CCMU_ADDR_UNIT1_CTRL) &&
            (busReq.wdata == `CCMU_RESET_BYTE)) begin
          cmpLatch[u] <= 1'b0; // [RULE_14]
        end else if (unitMode[u] == `CCMU_MODE_OFF) begin
          cmpLatch[u] <= 1'b0; // [RULE_03]
        end else if (matchEvent[u]) begin
          case (unitMode[u]) // [RULE_02]
            `CCMU_MODE_TOGGLE: cmpLatch[u] <= !cmpLatch[u];
            `CCMU_MODE_SET:    cmpLatch[u] <= 1'b1;
            `CCMU_MODE_CLEAR:  cmpLatch[u] <= 1'b0;
            default:           cmpLatch[u] <= cmpLatch[u];
          endcase
        end
      end
    end
  end

  // --------------------------------------------------------------
  // pin routing: enable low while the unit drives
  // --------------------------------------------------------------
  assign unit2OnB3 = altSel[`CCMU_ALT_UNIT2_BIT]; // [RULE_20]

  always_comb begin
    unit1Pin.out     = cmpLatch[0];
    unit1Pin.driveN  = !drivesPin(unitMode[0]); // [RULE_23] [RULE_06] [RULE_09]
    portC1Pin.out    = cmpLatch[1];
    portC1Pin.driveN = !(drivesPin(unitMode[1]) && !unit2OnB3); // [RULE_20] [RULE_23]
    portB3Pin.out    = cmpLatch[1];
    portB3Pin.driveN = !(drivesPin(unitMode[1]) && unit2OnB3); // [RULE_20] [RULE_23]
  end

  // --------------------------------------------------------------
  // register read port, data one cycle after the strobe
  // --------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      busRdata <= `CCMU_RESET_BYTE;
    end else if (busReq.rd) begin
      case (busReq.addr)
        `CCMU_ADDR_UNIT1_CTRL: busRdata <= unitCtrl[0];
        `CCMU_ADDR_UNIT2_CTRL: busRdata <= unitCtrl[1];
        `CCMU_ADDR_CMP1_LOW:   busRdata <= cmpVal[0][7:0];
        `CCMU_ADDR_CMP1_HIGH:  busRdata <= cmpVal[0][15:8];
        `CCMU_ADDR_CMP2_LOW:   busRdata <= cmpVal[1][7:0];
        `CCMU_ADDR_CMP2_HIGH:  busRdata <= cmpVal[1][15:8];
        `CCMU_ADDR_ALT_PIN:    busRdata <= altSel;
        `CCMU_ADDR_IRQ_EN1:    busRdata <= irqEn1;
        `CCMU_ADDR_IRQ_EN2:    busRdata <= irqEn2;
        `CCMU_ADDR_IRQ_FLAG1:  busRdata <= irqFlag1;
        `CCMU_ADDR_IRQ_FLAG2:  busRdata <= irqFlag2;
        `CCMU_ADDR_TB_LOW:     busRdata <= timeBaseCount[7:0];
        `CCMU_ADDR_TB_HIGH:    busRdata <= timeBaseCount[15:8];
        `CCMU_ADDR_TB_CTRL:    busRdata <= tbCtrl;
        default:               busRdata <= `CCMU_RESET_BYTE;
      endcase
    end else begin
      busRdata <= `CCMU_RESET_BYTE;
    end
  end

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  chk_trigger_same_cycle: assert property ( // [RULE_10]
    (unitMode[1] == `CCMU_MODE_SPECIAL && cmpVal[1] == timeBaseCount) |-> specialTrigger[1])
    else $error("special trigger missing in equality cycle");

  chk_timebase_clear: assert property ( // [RULE_11]
    (tick && specialTrigger != 2'h0 && !tbWrite) |=> (timeBaseCount == 16'h0000))
    else $error("time base not cleared after trigger");

  chk_cancelled_reset: assert property ( // [RULE_13]
    (tick && specialTrigger == 2'h0 && !tbWrite && timeBaseCount != 16'hffff)
      |=> (timeBaseCount == $past(timeBaseCount) + 16'h0001))
    else $error("time base reset without a standing match");

  chk_no_overflow_flag: assert property ( // [RULE_12]
    (tbReset && !wrHit(busReq, `CCMU_ADDR_IRQ_FLAG1)) |=> $stable(irqFlag1[`CCMU_FLAG1_OVF_BIT]))
    else $error("trigger set the overflow flag");

  chk_flag_on_match: assert property ( // [RULE_04]
    matchEvent[1] |=> irqFlag2[`CCMU_FLAG2_UNIT2_BIT])
    else $error("match flag not set");

  chk_flag_sticky: assert property ( // [RULE_05]
    (irqFlag1[`CCMU_FLAG1_UNIT1_BIT] && !wrHit(busReq, `CCMU_ADDR_IRQ_FLAG1))
      |=> irqFlag1[`CCMU_FLAG1_UNIT1_BIT])
    else $error("match flag cleared by hardware");

  chk_toggle_action: assert property ( // [RULE_02]
    (matchEvent[0] && unitMode[0] == `CCMU_MODE_TOGGLE && !busReq.wr) |=> (cmpLatch[0] != $past(cmpLatch[0])))
    else $error("toggle did not toggle");

  chk_swint_pin_free: assert property ( // [RULE_06]
    (unitMode[0] == `CCMU_MODE_SWINT) |-> unit1Pin.driveN)
    else $error("software interrupt mode drives the pin");

  chk_special_pin_free: assert property ( // [RULE_09]
    (unitMode[1] == `CCMU_MODE_SPECIAL) |-> (portC1Pin.driveN && portB3Pin.driveN))
    else $error("special event mode drives a pin");

  chk_zero_ctrl_latch: assert property ( // [RULE_14]
    (wrHit(busReq, `CCMU_ADDR_UNIT1_CTRL) && busReq.wdata == 8'h00) |=> (!cmpLatch[0] && unit1Pin.driveN))
    else $error("zero control write left latch high");

  chk_single_fire: assert property ( // [RULE_22]
    matchEvent[0] |=> !matchEvent[0])
    else $error("match fired twice for one count");

  chk_sleep_hold: assert property ( // [RULE_18]
    (sleepMode && !tbCtrl[`CCMU_TBCTRL_EXT_BIT] && !tbWrite) |=> $stable(timeBaseCount))
    else $error("instruction clocked time base moved in sleep");

  chk_adc_start_src: assert property ( // [RULE_08]
    adcStart |-> (unitMode[1] == `CCMU_MODE_SPECIAL && adcEnabled && specialTrigger[1]))
    else $error("conversion start without second unit trigger");

  chk_pin_route: assert property ( // [RULE_20]
    unit2OnB3 |-> portC1Pin.driveN)
    else $error("second unit drives unselected pin");

endmodule

// *** testbench/ccmu_pin_load.sv ***
// external load on the three compare output pins: a pull-down on each pin
module ccmu_pin_load
  import ccmu_pkg::*;
(
  input  wire ccmu_pin_t unit1Pin,
  input  wire ccmu_pin_t portC1Pin,
  input  wire ccmu_pin_t portB3Pin,
  output logic           level1,
  output logic           levelC1,
  output logic           levelB3
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // pin resolution
  // ------------------------------------------------------------
  // a released pin falls to the pull-down, never holds the last latch value
  assign level1  = unit1Pin.driveN  ? 1'b0 : unit1Pin.out;
  assign levelC1 = portC1Pin.driveN ? 1'b0 : portC1Pin.out;
  assign levelB3 = portB3Pin.driveN ? 1'b0 : portB3Pin.out;
endmodule

// *** testbench/test_compare_match_unit.sv ***
// self-checking bench for the compare match unit
`include "ccmu_cfg.svh"
module test_compare_match_unit
  import ccmu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic          core_clk, rst_n, sleepMode, extClkPin, adcEnabled, adcStart, level1, levelC1, levelB3;
  ccmu_bus_req_t busReq;
  logic [7:0]    busRdata;
  ccmu_pin_t     unit1Pin, portC1Pin, portB3Pin;
  logic [1:0]    specialTrigger;
  int            miscompares, n_checks, cycles, adcPulses;

  ccmu_compare_unit u_ccmu_compare_unit (.core_clk(core_clk), .rst_n(rst_n), .busReq(busReq),
    .busRdata(busRdata), .sleepMode(sleepMode), .extClkPin(extClkPin), .adcEnabled(adcEnabled),
    .unit1Pin(unit1Pin), .portC1Pin(portC1Pin), .portB3Pin(portB3Pin),
    .specialTrigger(specialTrigger), .adcStart(adcStart));
  ccmu_pin_load u_ccmu_pin_load (.unit1Pin(unit1Pin), .portC1Pin(portC1Pin), .portB3Pin(portB3Pin),
    .level1(level1), .levelC1(levelC1), .levelB3(levelB3));

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  // ------------------------------------------------------------
  // bookkeeping
  // ------------------------------------------------------------
  task conclude();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // the whole run needs about 800 cycles; the ceiling leaves wide margin
  always @(posedge core_clk) begin
    cycles++;
    if (adcStart === 1'b1) adcPulses++;
    if (cycles == 20000) begin
      miscompares++;
      conclude();
    end
  end

  task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  // ------------------------------------------------------------
  // register port
  // ------------------------------------------------------------
  task wrReg(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    busReq.addr <= a;
    busReq.wdata <= d;
    busReq.wr <= 1'b1;
    @(posedge core_clk);
    busReq.wr <= 1'b0;
  endtask

  task rdReg(input logic [3:0] a, output logic [7:0] d);
    @(posedge core_clk);
    busReq.addr <= a;
    busReq.rd <= 1'b1;
    @(posedge core_clk);
    busReq.rd <= 1'b0;
    #1 d = busRdata;
  endtask

  task rdCount(output logic [15:0] v);
    rdReg(`CCMU_ADDR_TB_LOW, v[7:0]);
    rdReg(`CCMU_ADDR_TB_HIGH, v[15:8]);
  endtask

  // the time base is stopped while its two bytes are loaded one at a time
  task setCount(input logic [15:0] v);
    wrReg(`CCMU_ADDR_TB_CTRL, 8'h00);
    wrReg(`CCMU_ADDR_TB_LOW, v[7:0]);
    wrReg(`CCMU_ADDR_TB_HIGH, v[15:8]);
  endtask

  task armMatch(input logic unit2, input logic [3:0] mode, input logic [15:0] cmp);
    logic [3:0] base;
    base = unit2 ? `CCMU_ADDR_CMP2_LOW : `CCMU_ADDR_CMP1_LOW;
    setCount(cmp - 16'h0003);
    wrReg(base, cmp[7:0]);
    wrReg(base + 4'h1, cmp[15:8]);
    wrReg(unit2 ? `CCMU_ADDR_UNIT2_CTRL : `CCMU_ADDR_UNIT1_CTRL, {4'h0, mode});
    wrReg(`CCMU_ADDR_IRQ_FLAG1, 8'h00);
    wrReg(`CCMU_ADDR_IRQ_FLAG2, 8'h00);
    wrReg(`CCMU_ADDR_TB_CTRL, 8'h01);
    repeat (24) @(posedge core_clk);
    wrReg(`CCMU_ADDR_TB_CTRL, 8'h00);
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task testReset();
    logic [7:0] d;
    logic [3:0] regs [8];
    regs = '{`CCMU_ADDR_UNIT1_CTRL, `CCMU_ADDR_UNIT2_CTRL, `CCMU_ADDR_ALT_PIN, `CCMU_ADDR_IRQ_EN1,
             `CCMU_ADDR_IRQ_EN2, `CCMU_ADDR_IRQ_FLAG1, `CCMU_ADDR_IRQ_FLAG2, 4'hf};
    foreach (regs[i]) begin
      rdReg(regs[i], d);
      check("reset value", d, 16'h0000);
    end
    @(posedge core_clk);
    #1 check("read data after its cycle", busRdata, 16'h0000);
    check("pins released", {unit1Pin.driveN, portC1Pin.driveN, portB3Pin.driveN}, 16'h0007);
    wrReg(`CCMU_ADDR_UNIT1_CTRL, 8'hff);
    rdReg(`CCMU_ADDR_UNIT1_CTRL, d);
    check("control unused bits", d, 16'h003f);
    wrReg(`CCMU_ADDR_UNIT1_CTRL, 8'h00);
    $display("test reset done");
  endtask

  task testModes();
    logic [7:0]  d;
    logic [15:0] cnt;
    logic [3:0]  modes [7];
    logic        latch [7];
    modes = '{`CCMU_MODE_TOGGLE, `CCMU_MODE_CLEAR, `CCMU_MODE_SET, `CCMU_MODE_TOGGLE,
              `CCMU_MODE_SWINT, `CCMU_MODE_SPECIAL, `CCMU_MODE_SET};
    latch = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
    foreach (modes[i]) begin
      armMatch(1'b0, modes[i], 16'h0120);
      rdReg(`CCMU_ADDR_IRQ_FLAG1, d);
      check("match flag", d[2], 16'h0001);
      check("overflow flag", d[0], 16'h0000);
      check("latch", unit1Pin.out, latch[i]);
      check("pin drive", unit1Pin.driveN, modes[i][1] & modes[i][3]);
      check("pin level", level1, latch[i] & ~(modes[i][1] & modes[i][3]));
      rdCount(cnt);
      check("count restarted", cnt < 16'h0120, modes[i] == `CCMU_MODE_SPECIAL);
    end
    check("no conversion from first unit", adcPulses, 16'h0000);
    wrReg(`CCMU_ADDR_UNIT1_CTRL, 8'h00);
    // the latch settles in the edge that takes the write, so look a little later
    #1 check("latch after zero write", {unit1Pin.out, unit1Pin.driveN}, 16'h0001);
    $display("test modes done");
  endtask

  task testUnit2();
    logic [7:0] d;
    int         p0;
    armMatch(1'b1, `CCMU_MODE_TOGGLE, 16'h0340);
    rdReg(`CCMU_ADDR_IRQ_FLAG2, d);
    check("second match flag", d, 16'h0001);
    check("port c pin", {levelC1, portC1Pin.driveN, portB3Pin.driveN}, 16'h0005);
    wrReg(`CCMU_ADDR_ALT_PIN, 8'h01);
    #1 check("port b pin", {levelB3, portB3Pin.driveN, portC1Pin.driveN}, 16'h0005);
    p0 = adcPulses;
    armMatch(1'b1, `CCMU_MODE_SPECIAL, 16'h0340);
    check("conversion start", adcPulses - p0, 16'h0001);
    check("pin released in special", portB3Pin.driveN, 16'h0001);
    @(posedge core_clk) adcEnabled <= 1'b0;
    armMatch(1'b1, `CCMU_MODE_SPECIAL, 16'h0340);
    check("no start while converter off", adcPulses - p0, 16'h0001);
    wrReg(`CCMU_ADDR_UNIT2_CTRL, 8'h00);
    $display("test second unit done");
  endtask

  task testCancel();
    logic [15:0] cnt;
    logic        seen;
    logic [7:0]  d;
    seen = 1'b0;
    setCount(16'h011d);
    wrReg(`CCMU_ADDR_CMP1_LOW, 8'h20);
    wrReg(`CCMU_ADDR_CMP1_HIGH, 8'h01);
    wrReg(`CCMU_ADDR_UNIT1_CTRL, 8'h0b);
    wrReg(`CCMU_ADDR_TB_CTRL, 8'h01);
    for (int i = 0; i < 40 && !seen; i++) begin
      @(posedge core_clk);
      #1 seen = (specialTrigger[0] === 1'b1);
    end
    check("trigger seen", seen, 16'h0001);
    wrReg(`CCMU_ADDR_CMP1_LOW, 8'h00);
    repeat (8) @(posedge core_clk);
    wrReg(`CCMU_ADDR_TB_CTRL, 8'h00);
    rdCount(cnt);
    check("reset withdrawn", cnt > 16'h0120, 16'h0001);
    // a trigger at the top of the count must not look like a wrap; a real wrap must
    armMatch(1'b0, `CCMU_MODE_SPECIAL, 16'hffff);
    rdReg(`CCMU_ADDR_IRQ_FLAG1, d);
    check("trigger at top of count", d[2:0], 16'h0004);
    armMatch(1'b0, `CCMU_MODE_SWINT, 16'hffff);
    rdReg(`CCMU_ADDR_IRQ_FLAG1, d);
    check("overflow by wrap", d[2:0], 16'h0005);
    wrReg(`CCMU_ADDR_UNIT1_CTRL, 8'h00);
    $display("test cancel done");
  endtask

  task testSleep();
    logic [15:0] cnt;
    setCount(16'h0050);
    @(posedge core_clk) sleepMode <= 1'b1;
    wrReg(`CCMU_ADDR_TB_CTRL, 8'h01);
    repeat (40) @(posedge core_clk);
    rdCount(cnt);
    check("count held in sleep", cnt, 16'h0050);
    @(posedge core_clk) sleepMode <= 1'b0;
    repeat (12) @(posedge core_clk);
    rdCount(cnt);
    check("count resumes", cnt > 16'h0050, 16'h0001);
    setCount(16'h0000);
    @(posedge core_clk) sleepMode <= 1'b1;
    wrReg(`CCMU_ADDR_TB_CTRL, 8'h03);
    repeat (5) begin
      @(posedge core_clk) extClkPin <= 1'b1;
      repeat (3) @(posedge core_clk);
      extClkPin <= 1'b0;
      repeat (3) @(posedge core_clk);
    end
    repeat (4) @(posedge core_clk);
    wrReg(`CCMU_ADDR_TB_CTRL, 8'h00);
    sleepMode <= 1'b0;
    rdCount(cnt);
    check("external count in sleep", cnt, 16'h0005);
    $display("test sleep done");
  endtask

  initial begin
    rst_n = 1'b0;
    busReq = '0;
    sleepMode = 1'b0;
    extClkPin = 1'b0;
    adcEnabled = 1'b1;
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    testReset();
    testModes();
    testUnit2();
    testCancel();
    testSleep();
    conclude();
  end
endmodule
